/* logic/cmpc_defines.vh */
// Purpose: shared constants for the comparator control block
// Assumes: AHB-Lite word registers, one block of four words per comparator
// Notes: offsets are byte addresses; bit positions refer to the low byte
`ifndef CMPC_DEFINES_VH
`define CMPC_DEFINES_VH

// ------------------------------------------------------------
// register map
// ------------------------------------------------------------
`define CMPC_STRIDE 8'h10
`define CMPC_OFS_CTRL 8'h00
`define CMPC_OFS_MODE 8'h04
`define CMPC_OFS_CHSEL 8'h08
`define CMPC_OFS_AUX 8'h0c

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define CMPC_CTRL_EN 7
`define CMPC_CTRL_OUT 6
`define CMPC_CTRL_RISE 5
`define CMPC_CTRL_FALL 4
`define CMPC_MODE_INV 6
`define CMPC_MODE_RIE 5
`define CMPC_MODE_FIE 4
`define CMPC_AUX_HOLD 0

// ------------------------------------------------------------
// reset values and encodings
// ------------------------------------------------------------
`define CMPC_RST_HYST 2'h0
`define CMPC_RST_TOPO 2'h0
`define CMPC_RST_RESP 2'h2
`define CMPC_RST_CHSEL 8'h00
`define CMPC_TOPO_DIRECT 2'h0
`define CMPC_TOPO_NEG_GND 2'h1
`define CMPC_TOPO_NEG_DAC 2'h2
`define CMPC_TOPO_POS_DAC 2'h3
`define CMPC_CODE_INT 4'ha
`define CMPC_CODE_VDD 4'hb
`define CMPC_SEL_W 12

`endif

/* logic/cmpc_ahb.v */
// Purpose: AHB-Lite slave front end for the comparator registers
// Assumes: zero wait states, single word transfers
// Notes: write data is committed in the data phase; reads are flagged in the address phase
`timescale 1ns/10ps
`default_nettype none
module cmpc_ahb (
  // clock and reset
  input wire clk_sys,
  input wire rst,
  // ahb-lite slave
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output wire hreadyout,
  output wire hresp,
  // register side
  output wire wr_stb,
  output wire [7:0] wr_addr,
  output wire [7:0] wr_data,
  output wire rd_stb,
  output wire [7:0] rd_addr
);

  reg wr_pend_ff;
  reg [7:0] wr_addr_ff;
  wire take;

  // a transfer is taken only when the bus is ready and htrans is nonseq or seq
  assign take = hsel & htrans[1] & hready;

  // remember write address phase; hsize unused since only words are issued
  always @(posedge clk_sys) begin
    if (rst) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end else begin
      wr_pend_ff <= take & hwrite;
      if (take & hwrite) begin
        wr_addr_ff <= {haddr[7:2], 2'b00};
      end
    end
  end

  // never stall, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wr_stb = wr_pend_ff;
  assign wr_addr = wr_addr_ff;
  assign wr_data = hwdata[7:0];
  assign rd_stb = take & ~hwrite;
  assign rd_addr = {haddr[7:2], 2'b00};

endmodule
`default_nettype wire

/* logic/cmpc_chan.v */
// Purpose: output path of one comparator: inversion, hold, synchroniser, edges
// Assumes: raw result is asynchronous; capture channel is on clk_sys
// Notes: while held, both outputs show the last synchronised value
`timescale 1ns/10ps
`default_nettype none
module cmpc_chan (
  // clock and reset
  input wire clk_sys,
  input wire rst,
  // analog result and controls
  input wire raw_gt,
  input wire enable,
  input wire invert,
  input wire hold_en,
  input wire capture,
  // outputs
  output wire async_out,
  output wire sync_out,
  output wire state,
  output wire rise_pulse,
  output wire fall_pulse
);

  reg sync1_ff;
  reg sync2_ff;
  reg hold_ff;
  reg prev_ff;
  wire inv_raw;
  wire holding;
  wire held_sync;

  // inversion is applied on both the raw and the synchronised path so every consumer sees it
  assign inv_raw = raw_gt ^ invert;
  assign holding = hold_en & ~capture;

  // two-flop synchroniser on the raw pin alone; inversion comes after the
  // second flop, and only async_out reads the unsynchronised level
  always @(posedge clk_sys) begin
    if (rst) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      hold_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      sync1_ff <= raw_gt;
      sync2_ff <= sync1_ff;
      if (!holding) begin
        hold_ff <= sync2_ff ^ invert;
      end
      prev_ff <= sync_out;
    end
  end

  assign held_sync = holding ? hold_ff : (sync2_ff ^ invert);
  // disabled comparator drives its outputs low
  assign async_out = enable & (holding ? hold_ff : inv_raw);
  assign sync_out = enable & held_sync;
  assign state = sync_out;
  // edges of the synchronised output only, so a glitch on raw cannot double-set
  assign rise_pulse = sync_out & ~prev_ff;
  assign fall_pulse = ~sync_out & prev_ff;

endmodule
`default_nettype wire

/* logic/cmpc_top.v */
// Purpose: control logic for two analog comparators behind an AHB-Lite slave
// Assumes: one clock clk_sys at 25 MHz, synchronous active-high reset
// Notes: analog mux and topology controls are one-hot/level outputs to the analog macro
//
// The AHB-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "cmpc_defines.vh"
module cmpc_top #(
  parameter NCMP = 2
) (
  // clock and reset
  input wire clk_sys,
  input wire rst,
  // ahb-lite slave
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output wire hreadyout,
  output wire hresp,
  output wire [31:0] hrdata,
  // analog comparator results, asynchronous
  input wire [1:0] cmp_raw_gt,
  // counter-array capture channel two output
  input wire capture_channel_two_output,
  // analog controls, first comparator in low bits
  output wire [1:0] cmp_power_on,
  output wire [23:0] pos_sel_onehot,
  output wire [23:0] neg_sel_onehot,
  output wire [1:0] dac_on_pos,
  output wire [1:0] dac_on_neg,
  output wire [1:0] neg_to_ground,
  output wire [3:0] pos_hyst,
  output wire [3:0] neg_hyst,
  output wire [3:0] resp_mode,
  // crossbar and system outputs
  output wire [1:0] sync_out,
  output wire [1:0] async_out,
  output wire reset_source,
  output wire kill_trigger,
  output wire [1:0] cmp_irq
);

  // ------------------------------------------------------------
  // select code decode
  // ------------------------------------------------------------
  // bit n<nports is port n, bit 10 internal node (regulator or ground), bit 11 supply
  function [`CMPC_SEL_W-1:0] sel_dec;
    input [3:0] code;
    input [3:0] nports;
    begin
      sel_dec = {`CMPC_SEL_W{1'b0}};
      if (code < nports) begin
        sel_dec[code] = 1'b1;
      end else if (code == `CMPC_CODE_INT) begin
        sel_dec[10] = 1'b1;
      end else if (code == `CMPC_CODE_VDD) begin
        sel_dec[11] = 1'b1;
      end
    end
  endfunction

  // ------------------------------------------------------------
  // bus front end
  // ------------------------------------------------------------
  wire wr_stb;
  wire [7:0] wr_addr;
  wire [7:0] wr_data;
  wire rd_stb;
  wire [7:0] rd_addr;
  reg [31:0] hrdata_ff;
  wire [7:0] rd_byte [0:NCMP-1];
  wire [NCMP-1:0] rd_hit;
  // reset select word split into nibbles on purpose, no silent truncation
  localparam [7:0] RST_CHSEL = `CMPC_RST_CHSEL;

  cmpc_ahb u_ahb (
    .clk_sys(clk_sys),
    .rst(rst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .hwdata(hwdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .wr_stb(wr_stb),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .rd_stb(rd_stb),
    .rd_addr(rd_addr)
  );

  // ------------------------------------------------------------
  // per-comparator registers and output path
  // ------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NCMP; gi = gi + 1) begin : g_cmp
      localparam [31:0] BASE_W = `CMPC_STRIDE * gi;
      localparam [7:0] BASE = BASE_W[7:0];
      // port count: ten on both muxes of the first comparator, nine on the second comparator
      localparam [3:0] NPOS = (gi == 0) ? 4'ha : 4'h9;
      localparam [3:0] NNEG = (gi == 0) ? 4'ha : 4'h9;
      reg en_ff;
      reg rise_ff;
      reg fall_ff;
      reg [1:0] hyp_ff;
      reg [1:0] hyn_ff;
      reg inv_ff;
      reg rie_ff;
      reg fie_ff;
      reg [1:0] topo_ff;
      reg [1:0] resp_ff;
      reg [3:0] psel_ff;
      reg [3:0] nsel_ff;
      reg hold_ff;
      reg [7:0] rd_mux;
      wire wr_ctrl;
      wire wr_mode;
      wire wr_chsel;
      wire wr_aux;
      wire st;
      wire rise_p;
      wire fall_p;
      wire [`CMPC_SEL_W-1:0] pdec;
      wire [`CMPC_SEL_W-1:0] ndec;

      assign wr_ctrl = wr_stb & (wr_addr == BASE + `CMPC_OFS_CTRL);
      assign wr_mode = wr_stb & (wr_addr == BASE + `CMPC_OFS_MODE);
      assign wr_chsel = wr_stb & (wr_addr == BASE + `CMPC_OFS_CHSEL);
      assign wr_aux = wr_stb & (wr_addr == BASE + `CMPC_OFS_AUX);

      // control register; flags cleared by writing 0, a new edge in the
      // same cycle wins so no event is lost
      always @(posedge clk_sys) begin
        if (rst) begin
          en_ff <= 1'b0;
          rise_ff <= 1'b0;
          fall_ff <= 1'b0;
          hyp_ff <= `CMPC_RST_HYST;
          hyn_ff <= `CMPC_RST_HYST;
        end else begin
          if (wr_ctrl) begin
            en_ff <= wr_data[`CMPC_CTRL_EN];
            hyp_ff <= wr_data[3:2];
            hyn_ff <= wr_data[1:0];
          end
          if (rise_p) begin
            rise_ff <= 1'b1;
          end else if (wr_ctrl && !wr_data[`CMPC_CTRL_RISE]) begin
            rise_ff <= 1'b0;
          end
          if (fall_p) begin
            fall_ff <= 1'b1;
          end else if (wr_ctrl && !wr_data[`CMPC_CTRL_FALL]) begin
            fall_ff <= 1'b0;
          end
        end
      end

      // mode, channel select and auxiliary registers
      always @(posedge clk_sys) begin
        if (rst) begin
          inv_ff <= 1'b0;
          rie_ff <= 1'b0;
          fie_ff <= 1'b0;
          topo_ff <= `CMPC_RST_TOPO;
          resp_ff <= `CMPC_RST_RESP;
          psel_ff <= RST_CHSEL[7:4];
          nsel_ff <= RST_CHSEL[3:0];
          hold_ff <= 1'b0;
        end else begin
          if (wr_mode) begin
            inv_ff <= wr_data[`CMPC_MODE_INV];
            rie_ff <= wr_data[`CMPC_MODE_RIE];
            fie_ff <= wr_data[`CMPC_MODE_FIE];
            topo_ff <= wr_data[3:2];
            resp_ff <= wr_data[1:0];
          end
          if (wr_chsel) begin
            psel_ff <= wr_data[7:4];
            nsel_ff <= wr_data[3:0];
          end
          if (wr_aux) begin
            hold_ff <= wr_data[`CMPC_AUX_HOLD];
          end
        end
      end

      cmpc_chan u_chan (
        .clk_sys(clk_sys),
        .rst(rst),
        .raw_gt(cmp_raw_gt[gi]),
        .enable(en_ff),
        .invert(inv_ff),
        .hold_en(hold_ff),
        .capture(capture_channel_two_output),
        .async_out(async_out[gi]),
        .sync_out(sync_out[gi]),
        .state(st),
        .rise_pulse(rise_p),
        .fall_pulse(fall_p)
      );

      // mux decode; unlisted codes give all zeros, leaving the input open
      assign pdec = sel_dec(psel_ff, NPOS);
      assign ndec = sel_dec(nsel_ff, NNEG);
      // grounded topology takes the negative input off the mux
      assign pos_sel_onehot[gi*12 +: 12] = pdec;
      assign neg_sel_onehot[gi*12 +: 12] =
        (topo_ff == `CMPC_TOPO_NEG_GND) ? {`CMPC_SEL_W{1'b0}} : ndec;
      assign neg_to_ground[gi] = (topo_ff == `CMPC_TOPO_NEG_GND);
      assign dac_on_neg[gi] = (topo_ff == `CMPC_TOPO_NEG_DAC);
      assign dac_on_pos[gi] = (topo_ff == `CMPC_TOPO_POS_DAC);
      assign cmp_power_on[gi] = en_ff;
      assign pos_hyst[gi*2 +: 2] = hyp_ff;
      assign neg_hyst[gi*2 +: 2] = hyn_ff;
      assign resp_mode[gi*2 +: 2] = resp_ff;
      assign cmp_irq[gi] = (rise_ff & rie_ff) | (fall_ff & fie_ff);

      // read mux for this comparator
      always @* begin
        rd_mux = 8'h00;
        case (rd_addr - BASE)
          `CMPC_OFS_CTRL: begin
            rd_mux = {en_ff, st, rise_ff, fall_ff, hyp_ff, hyn_ff};
          end
          `CMPC_OFS_MODE: begin
            rd_mux = {1'b0, inv_ff, rie_ff, fie_ff, topo_ff, resp_ff};
          end
          `CMPC_OFS_CHSEL: begin
            rd_mux = {psel_ff, nsel_ff};
          end
          `CMPC_OFS_AUX: begin
            rd_mux = {7'h00, hold_ff};
          end
          default: begin
            rd_mux = 8'h00;
          end
        endcase
      end
      assign rd_hit[gi] = (rd_addr >= BASE) && (rd_addr < BASE + `CMPC_STRIDE);
      assign rd_byte[gi] = rd_hit[gi] ? rd_mux : 8'h00;
    end
  endgenerate

  // ------------------------------------------------------------
  // read data register
  // ------------------------------------------------------------
  // unmapped addresses read as zero; captured at the address phase edge
  always @(posedge clk_sys) begin
    if (rst) begin
      hrdata_ff <= 32'h00000000;
    end else if (rd_stb) begin
      hrdata_ff <= {24'h000000, rd_byte[0] | rd_byte[1]};
    end
  end
  assign hrdata = hrdata_ff;

  // first comparator also serves reset and kill logic, after inversion
  assign reset_source = async_out[0];
  assign kill_trigger = async_out[0];

endmodule
`default_nettype wire

/* verif/cmpc_analog.sv */
// Purpose: analog node model behind the comparator control block
// Assumes: every node is plainly high or low; the reference dac is not modelled
// Notes: an open or unpowered input gives a result that flips each cycle
`timescale 1ns/10ps
`default_nettype none
module cmpc_analog (
  // clock and block controls
  input wire logic clk_sys,
  input wire logic [1:0] cmp_power_on,
  input wire logic [23:0] pos_sel_onehot,
  input wire logic [23:0] neg_sel_onehot,
  input wire logic [1:0] neg_to_ground,
  // node levels from the bench
  input wire logic [23:0] node_hi,
  // comparator results
  output logic [1:0] cmp_raw_gt
);
  logic [1:0] junk_ff = 2'h1;
  logic [11:0] ps, ns;
  // floating result pattern, so the simulator never settles it for us
  always @(posedge clk_sys) junk_ff <= ~junk_ff;
  // mux pick and compare per comparator
  always @* begin
    for (int i = 0; i < 2; i++) begin
      ps = pos_sel_onehot[i*12 +: 12];
      ns = neg_sel_onehot[i*12 +: 12];
      if (!cmp_power_on[i] || ps == 12'h0 || (ns == 12'h0 && !neg_to_ground[i])) begin
        cmp_raw_gt[i] = junk_ff[i];
      end else begin
        cmp_raw_gt[i] = |(ps & node_hi[i*12 +: 12]) & !(neg_to_ground[i]
          || |(ns & node_hi[i*12 +: 12]));
      end
    end
  end
endmodule
`default_nettype wire

/* verif/cmpc_top_monitor.sv */
// Purpose: port checks for the comparator control block
// Assumes: one clock domain; writes reach outputs two edges after the address phase
// Notes: register contents are hidden, so outputs are tied to bus events
`timescale 1ns/10ps
`default_nettype none
module cmpc_monitor #(
  parameter NCMP = 2
) (
  // clock, reset and bus
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // comparator side
  input wire logic capture_channel_two_output,
  input wire logic [1:0] cmp_power_on,
  input wire logic [23:0] pos_sel_onehot,
  input wire logic [23:0] neg_sel_onehot,
  input wire logic [1:0] dac_on_pos,
  input wire logic [1:0] dac_on_neg,
  input wire logic [1:0] neg_to_ground,
  input wire logic [3:0] pos_hyst,
  input wire logic [3:0] neg_hyst,
  input wire logic [1:0] sync_out,
  input wire logic [1:0] async_out,
  input wire logic reset_source,
  input wire logic kill_trigger,
  input wire logic [1:0] cmp_irq
);
  // a transfer accepted in its address phase
  wire logic take = hsel && htrans[1] && hready;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // ----------------
  // checks
  // ----------------
  a_off_low: assert property (!cmp_power_on[0] |-> !async_out[0] && !sync_out[0])
    else $error("disabled output not low");
  a_route_same: assert property (reset_source == async_out[0] && kill_trigger == async_out[0])
    else $error("reset or kill route differs");
  a_sync_track: assert property ((cmp_power_on[0] && capture_channel_two_output
    && $stable(async_out[0]))[*3] |-> sync_out[0] == async_out[0]) else $error("sync lags");
  a_irq_cause: assert property ($rose(cmp_irq[0]) |->
    $past(sync_out[0]) != $past(sync_out[0], 2) || $past(take && hwrite, 2))
    else $error("interrupt without edge");
  a_cfg_write: assert property ($changed(pos_hyst) || $changed(pos_sel_onehot)
    |-> $past(take && hwrite, 2) || $past(rst)) else $error("config moved unwritten");
  a_sel_decode: assert property ($onehot0(pos_sel_onehot[11:0]) && $onehot0(neg_sel_onehot[11:0])
    && $onehot0(pos_sel_onehot[23:12]) && !pos_sel_onehot[21] && !neg_sel_onehot[21])
    else $error("bad select decode");
  a_topo_excl: assert property (!(dac_on_pos[0] && dac_on_neg[0]) && !(neg_to_ground[0]
    && (dac_on_neg[0] || neg_sel_onehot[11:0] != 12'h0))) else $error("topology clash");
  a_rdata_hold: assert property ($changed(hrdata) |-> $past(take && !hwrite) || $past(rst))
    else $error("read data moved");
  c_irq: cover property ($rose(cmp_irq[0]));
  c_ground: cover property (neg_to_ground[0]);
  c_hold: cover property (!capture_channel_two_output && cmp_power_on[0]);
endmodule
bind cmpc_top cmpc_monitor #(.NCMP(NCMP)) mon (.clk_sys(clk_sys), .rst(rst), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .capture_channel_two_output(capture_channel_two_output), .cmp_power_on(cmp_power_on),
  .pos_sel_onehot(pos_sel_onehot), .neg_sel_onehot(neg_sel_onehot), .dac_on_pos(dac_on_pos),
  .dac_on_neg(dac_on_neg), .neg_to_ground(neg_to_ground), .pos_hyst(pos_hyst),
  .neg_hyst(neg_hyst), .sync_out(sync_out), .async_out(async_out),
  .reset_source(reset_source), .kill_trigger(kill_trigger), .cmp_irq(cmp_irq));
`default_nettype wire

/* verif/cmpc_top_tb.sv */
// Purpose: self-checking bench for the comparator control block
// Assumes: zero-wait bus slave; analog nodes come from cmpc_analog
// Notes: flags and output level are kept in integer models here
`timescale 1ns/10ps
`default_nettype none
module comparator_control_logic_tb;
  logic clk_sys = 1'h0, rst = 1'h1, hsel = 1'h0, hwrite = 1'h0, capture = 1'h1;
  logic [7:0] haddr = 8'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, hrdata;
  logic [23:0] node_hi = 24'h800800, pos_sel_onehot, neg_sel_onehot;
  logic [1:0] cmp_raw_gt, cmp_power_on, dac_on_pos, dac_on_neg, neg_to_ground;
  logic [1:0] sync_out, async_out, cmp_irq;
  logic [3:0] pos_hyst, neg_hyst, resp_mode;
  logic hreadyout, hresp, reset_source, kill_trigger;
  int n_errors = 0, checked = 0, mo = 0, mr = 0, mf = 0, inv = 0, en = 0, hv;
  integer seed = 50;
  // ----------------
  // design and far side
  // ----------------
  cmpc_top uut (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cmp_raw_gt(cmp_raw_gt),
    .capture_channel_two_output(capture), .cmp_power_on(cmp_power_on),
    .pos_sel_onehot(pos_sel_onehot), .neg_sel_onehot(neg_sel_onehot), .dac_on_pos(dac_on_pos),
    .dac_on_neg(dac_on_neg), .neg_to_ground(neg_to_ground), .pos_hyst(pos_hyst),
    .neg_hyst(neg_hyst), .resp_mode(resp_mode), .sync_out(sync_out), .async_out(async_out),
    .reset_source(reset_source), .kill_trigger(kill_trigger), .cmp_irq(cmp_irq));
  cmpc_analog far (.clk_sys(clk_sys), .cmp_power_on(cmp_power_on), .node_hi(node_hi),
    .pos_sel_onehot(pos_sel_onehot), .neg_sel_onehot(neg_sel_onehot),
    .neg_to_ground(neg_to_ground), .cmp_raw_gt(cmp_raw_gt));
  // 25 mhz system clock
  always #20 clk_sys = ~clk_sys;
  // ----------------
  // tasks
  // ----------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_rdy(inout int k);
    do begin
      @(posedge clk_sys);
      k++;
    end while (hreadyout !== 1'h1 && k < 99);
  endtask
  // one single transfer; read data taken at the data-phase edge
  task automatic ahb(input logic w, input logic [7:0] a, d, output logic [31:0] r);
    int k;
    k = 0;
    @(posedge clk_sys);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wait_rdy(k);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_rdy(k);
    r = hrdata;
    if (k >= 99) begin
      n_errors++;
      $display("ERROR %0t bus hang", $time);
      close_out();
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    logic [31:0] r;
    ahb(1'h1, a, d, r);
  endtask
  task automatic rdc(input logic [7:0] a, input int e);
    logic [31:0] r;
    ahb(1'h0, a, 8'h0, r);
    chk(r, e);
  endtask
  // sync stage plus flag stage have settled after four edges
  task automatic step();
    int o;
    repeat (4) @(posedge clk_sys);
    o = en ? ((node_hi[1] > node_hi[2]) ^ inv) : 0;
    if (o > mo) mr = 1;
    if (o < mo) mf = 1;
    mo = o;
  endtask
  function automatic int ctrl();
    return 128 * en + 64 * mo + 32 * mr + 16 * mf;
  endfunction
  // ports below the last port code, then regulator or ground, then supply
  function automatic logic [11:0] exp_sel(input int code, c);
    if (code < 10 - c) return 12'h1 << code;
    if (code == 10) return 12'h400;
    if (code == 11) return 12'h800;
    return 12'h0;
  endfunction
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    close_out();
  end
  // main sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'h0;
    chk(resp_mode, 10);
    chk(hresp, 0);
    for (int a = 0; a <= 32; a += 4) rdc(a, (a == 4 || a == 20) ? 2 : 0);
    $display("reset values done");
    for (int c = 0; c < 2; c++) begin
      for (int code = 0; code < 16; code++) begin
        wr(16 * c + 8, 17 * code);
        #1;
        chk(pos_sel_onehot >> 12 * c & 12'hfff, exp_sel(code, c));
        chk(neg_sel_onehot >> 12 * c & 12'hfff, exp_sel(code, c));
        rdc(16 * c + 8, 17 * code);
      end
    end
    $display("decode done");
    wr(8, 8'h12);
    for (int t = 0; t < 4; t++) begin
      wr(4, 4 * t);
      #1;
      chk({dac_on_pos[0], dac_on_neg[0], neg_to_ground[0]}, {t == 3, t == 2, t == 1});
      chk(neg_sel_onehot[11:0], t == 1 ? 0 : 4);
      hv = $random(seed) & 15;
      wr(0, hv);
      #1;
      chk({pos_hyst[1:0], neg_hyst[1:0]}, hv);
      rdc(0, hv);
    end
    wr(4, 8'h0);
    $display("topology done");
    node_hi[1] <= 1'h1;
    en = 1;
    wr(0, 8'h80);
    step();
    chk(cmp_power_on, 1);
    chk(reset_source, mo);
    wr(0, 8'h80);
    mr = 0;
    mf = 0;
    rdc(0, ctrl());
    inv = 1;
    wr(4, 8'h40);
    step();
    rdc(0, ctrl());
    chk(kill_trigger, mo);
    wr(4, 8'h60);
    node_hi[1] <= 1'h0;
    #1;
    chk(cmp_irq[0], 0);
    step();
    chk(cmp_irq[0], mr);
    node_hi[1] <= 1'h1;
    step();
    rdc(0, ctrl());
    wr(0, 8'h80);
    mr = 0;
    mf = 0;
    rdc(0, ctrl());
    chk(cmp_irq[0], 0);
    $display("edges done");
    wr(12, 8'h1);
    capture <= 1'h0;
    node_hi[1] <= 1'h0;
    repeat (4) @(posedge clk_sys);
    chk({sync_out[0], async_out[0]}, 2 * mo + mo);
    capture <= 1'h1;
    step();
    chk(sync_out[0], mo);
    en = 0;
    wr(0, 8'h0);
    mr = 0;
    mf = 0;
    step();
    rdc(0, ctrl());
    chk({cmp_power_on[0], sync_out[0], async_out[0]}, 0);
    $display("hold and disable done");
    wr(8'h18, 8'hab);
    wr(8'h14, 8'h40);
    wr(8'h10, 8'h80);
    step();
    chk({sync_out[1], async_out[1]}, 3);
    $display("second comparator done");
    close_out();
  end
endmodule
`default_nettype wire
